// *** include/operand_access_pkg.sv ***
/*
  constants for the operand access unit: word and byte address layout,
  byte lanes, memory span and the operation classes, general and word-wide.
  assumes a 16-bit memory of 32768 words.
*/
package operand_access_pkg;
  // ==========================================================
  // widths and memory span
  localparam int WORD_W          = 16;
  localparam int BYTE_W          = 8;
  localparam int MEM_WORDS       = 32768;
  localparam int MEM_BYTES       = 65536;
  localparam int WADDR_W         = 15;
  // ==========================================================
  // field positions
  localparam int PTR_CHAIN_BIT   = 15;
  localparam int BYTE_SEL_BIT    = 0;
  localparam int HI_LANE_LSB     = 8;
  localparam int LO_LANE_LSB     = 0;
  // ==========================================================
  // reset values
  localparam logic       MODE_RESET = 1'b0;
  localparam logic [15:0] ZERO_WORD = 16'h0000;
  localparam logic [7:0]  ZERO_BYTE = 8'h00;
  // ==========================================================
  // operation classes
  typedef enum logic [2:0] {
    OP_GENERAL                  = 3'b000,
    OP_INCREMENT_MEMORY_AND_SKIP = 3'b001,
    OP_MULTIPLY                 = 3'b010,
    OP_DIVIDE                   = 3'b011,
    OP_NORMALIZE                = 3'b100,
    OP_JUMP                     = 3'b101,
    OP_JUMP_AND_STORE           = 3'b110
  } op_class_t;
  // ==========================================================
  // cycle kinds on the memory port
  typedef enum logic [1:0] {
    CYC_FETCH   = 2'b00,
    CYC_POINTER = 2'b01,
    CYC_OPERAND = 2'b10
  } cycle_kind_t;
endpackage

// *** src/operand_access.sv ***
/*
  operand access unit: keeps the word/byte mode, forms memory addresses,
  walks indirect pointers and loads operands into a destination register.
  assumes a memory that answers a read with rdValid some cycles later and
  accepts one request at a time; the sequencer waits for done.
*/
// Summary of operation
// - word mode loads full sixteen bits
// - byte load fills low byte, clears high
// - byte always lands in register low byte
// - byte operands are zero extended, unsigned
// - peripheral input stored low byte, high zero
// - memory spans 32768 words, 65536 bytes
// - word address bits 0-14, bit 15 zero
// - byte address word in bits 15-1
// - select bit zero high byte, one low
// - general operand addresses follow current mode
// - fetch and pointer cycles always word addressed
// - one indirect level bytes, unlimited words
// - byte pointer used directly as byte address
// - word pointer bits 0-14 give next word
// - word pointer bit 15 set fetches again
// - consecutive byte addresses step through buffers
// - two commands switch mode, mode persists
// - listed arithmetic and jump ops stay word wide
// - byte mode alters only address and operand
`timescale 1ns/1ps
module operand_access (
  input  wire logic                          mclk,
  input  wire logic                          rst,
  input  wire logic                          setByteMode,   // mode command pulse
  input  wire logic                          setWordMode,   // mode command pulse
  input  wire logic                          start,         // operand request pulse
  input  wire operand_access_pkg::op_class_t opClass,       // class of the instruction
  input  wire logic                          indirect,      // first address is a pointer
  input  wire logic [15:0]                   effAddr,       // effective address
  input  wire logic                          fetchReq,      // instruction fetch request
  input  wire logic [14:0]                   fetchAddr,     // program counter
  input  wire logic                          peripheralIn,  // store peripheral data
  input  wire logic [7:0]                    peripheralByte,
  input  wire logic [15:0]                   rdData,        // memory read data
  input  wire logic                          rdValid,       // memory read answer
  output      logic [15:0]                   memAddr,       // word address to memory
  output      logic                          memRead,
  output      logic                          memWrite,
  output      logic [15:0]                   memWData,
  output      logic [15:0]                   regData,       // destination register value
  output      logic                          regLoad,       // one-cycle load strobe
  output      logic [15:0]                   nextByteAddr,  // stepped byte address
  output      logic                          byteMode,      // current mode
  output      logic                          busy
);
  // ==========================================================
  // state
  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_POINTER = 2'b01,
    ST_OPERAND = 2'b10,
    ST_FETCH   = 2'b11
  } state_t;

  state_t      state;           // sequencer state
  state_t      next_state;
  logic [15:0] curAddr;         // address being resolved
  logic [15:0] next_curAddr;
  logic        opByte;          // this access is byte wide
  logic        next_opByte;
  logic        next_mode;

  // ==========================================================
  // helpers
  // word address form: location in 0-14, top bit zero
  function automatic logic [15:0] word_form(input logic [14:0] loc);
    word_form = {1'b0, loc};
  endfunction

  // selects a byte lane and zero extends it into the low byte
  function automatic logic [15:0] lane_pick(input logic [15:0] w, input logic sel);
    lane_pick = sel ? {operand_access_pkg::ZERO_BYTE, w[7:0]}
                    : {operand_access_pkg::ZERO_BYTE, w[15:8]};
  endfunction

  // ==========================================================
  // decode
  wire wordOnly = (opClass != operand_access_pkg::OP_GENERAL);
  wire useByte  = byteMode && !wordOnly;
  // byte address: word in bits 15-1, lane in bit 0
  wire [14:0] byteWordLoc = curAddr[15:1];
  wire        byteLane    = curAddr[operand_access_pkg::BYTE_SEL_BIT];
  wire        chainOn     = rdData[operand_access_pkg::PTR_CHAIN_BIT];
  wire [15:0] operandVal  = opByte ? lane_pick(rdData, byteLane) : rdData;

  // mode flip: word command wins if both arrive together
  assign next_mode = setWordMode ? 1'b0 : (setByteMode ? 1'b1 : byteMode);

  // ==========================================================
  // next state
  always_comb begin
    next_state  = state;
    next_curAddr = curAddr;
    next_opByte = opByte;
    unique case (state)
      ST_IDLE: begin
        if (start) begin
          next_opByte  = useByte;
          next_curAddr = effAddr;
          next_state   = indirect ? ST_POINTER : ST_OPERAND;
        end else if (fetchReq) begin
          next_curAddr = word_form(fetchAddr);
          next_state   = ST_FETCH;
        end
      end
      ST_POINTER: begin
        if (rdValid) begin
          if (opByte) begin
            next_curAddr = rdData;
            next_state   = ST_OPERAND;
          end else begin
            next_curAddr = word_form(rdData[14:0]);
            next_state   = chainOn ? ST_POINTER : ST_OPERAND;
          end
        end
      end
      ST_OPERAND: begin
        if (rdValid) begin
          next_state = ST_IDLE;
        end
      end
      ST_FETCH: begin
        if (rdValid) begin
          next_state = ST_IDLE;
        end
      end
    endcase
  end

  // ==========================================================
  // memory address: pointer and fetch cycles are word addressed
  wire [15:0] wordAddrNow = word_form(curAddr[14:0]);
  wire [15:0] opAddrNow   = opByte ? word_form(byteWordLoc) : wordAddrNow;
  wire [15:0] next_memAddr = (next_state == ST_OPERAND) ?
                             (next_opByte ? word_form(next_curAddr[15:1])
                                          : word_form(next_curAddr[14:0]))
                           : word_form(next_curAddr[14:0]);

  // ==========================================================
  // sequencer registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      state    <= ST_IDLE;
      curAddr  <= operand_access_pkg::ZERO_WORD;
      opByte   <= 1'b0;
      byteMode <= operand_access_pkg::MODE_RESET;
    end else begin
      state    <= next_state;
      curAddr  <= next_curAddr;
      opByte   <= next_opByte;
      byteMode <= next_mode;
    end
  end

  // memory request outputs, registered
  always_ff @(posedge mclk) begin
    if (rst) begin
      memAddr <= operand_access_pkg::ZERO_WORD;
      memRead <= 1'b0;
    end else begin
      memAddr <= next_memAddr;
      // one read per cycle entered; re-issued on each chained pointer
      memRead <= (next_state != ST_IDLE) &&
                 ((state == ST_IDLE) || rdValid);
    end
  end

  // register load
  always_ff @(posedge mclk) begin
    if (rst) begin
      regData <= operand_access_pkg::ZERO_WORD;
      regLoad <= 1'b0;
    end else begin
      regLoad <= (state == ST_OPERAND) && rdValid;
      if ((state == ST_OPERAND) && rdValid) begin
        regData <= operandVal;
      end
    end
  end

  // peripheral input stored one byte per word, high byte cleared
  always_ff @(posedge mclk) begin
    if (rst) begin
      memWrite <= 1'b0;
      memWData <= operand_access_pkg::ZERO_WORD;
    end else begin
      memWrite <= peripheralIn && (state == ST_IDLE);
      if (peripheralIn) begin
        memWData <= {operand_access_pkg::ZERO_BYTE, peripheralByte};
      end
    end
  end

  // stepping: the next consecutive byte address, wraps over 65536
  always_ff @(posedge mclk) begin
    if (rst) begin
      nextByteAddr <= operand_access_pkg::ZERO_WORD;
    end else if ((state == ST_OPERAND) && rdValid) begin
      nextByteAddr <= curAddr + 16'h0001;
    end
  end

  assign busy = (state != ST_IDLE);

  // ==========================================================
  // checks
  sequence s_ptr_done;
    (state == ST_POINTER) && rdValid;
  endsequence

  // the answer that completes an operand read
  sequence s_operand_done;
    (state == ST_OPERAND) && rdValid;
  endsequence

  a_word_load: assert property (@(posedge mclk) disable iff (rst)
    (state == ST_OPERAND && rdValid && !opByte) |=> regLoad && regData == $past(rdData))
    else $error("word load altered data");
  a_byte_high_zero: assert property (@(posedge mclk) disable iff (rst)
    (state == ST_OPERAND && rdValid && opByte) |=> regData[15:8] == 8'h00)
    else $error("byte load high byte not zero");
  a_byte_lane_low: assert property (@(posedge mclk) disable iff (rst)
    (state == ST_OPERAND && rdValid && opByte && !curAddr[0])
      |=> regData[7:0] == $past(rdData[15:8]))
    else $error("byte select zero took wrong lane");
  a_word_addr_top: assert property (@(posedge mclk) disable iff (rst)
    memRead |-> memAddr[15] == 1'b0)
    else $error("word address bit 15 set");
  a_byte_one_level: assert property (@(posedge mclk) disable iff (rst)
    (s_ptr_done and opByte) |=> state == ST_OPERAND)
    else $error("byte pointer chained");
  a_chain_again: assert property (@(posedge mclk) disable iff (rst)
    (s_ptr_done and (!opByte && rdData[15])) |=> state == ST_POINTER && memRead)
    else $error("word chain did not refetch");
  a_chain_end: assert property (@(posedge mclk) disable iff (rst)
    (s_ptr_done and (!opByte && !rdData[15]))
      |=> state == ST_OPERAND && memAddr == {1'b0, $past(rdData[14:0])})
    else $error("word chain end address wrong");
  a_word_only_ops: assert property (@(posedge mclk) disable iff (rst)
    (state == ST_IDLE && start && opClass != operand_access_pkg::OP_GENERAL) |=> !opByte)
    else $error("word-only op ran as byte");
  a_periph_pack: assert property (@(posedge mclk) disable iff (rst)
    memWrite |-> memWData[15:8] == 8'h00)
    else $error("peripheral word high byte not zero");
  a_mode_sticks: assert property (@(posedge mclk) disable iff (rst)
    (!setByteMode && !setWordMode) |=> byteMode == $past(byteMode))
    else $error("mode changed without command");

  // ==========================================================
  // checks: operand completion and lanes
  // lane one is the low byte of the word
  a_byte_lane_one: assert property (@(posedge mclk) disable iff (rst)
    (state == ST_OPERAND && rdValid && opByte && curAddr[0])
      |=> regData[7:0] == $past(rdData[7:0]))
    else $error("byte select one took wrong lane");
  // a byte pointer is taken whole as the next byte address
  a_byte_pointer_use: assert property (@(posedge mclk) disable iff (rst)
    (s_ptr_done and opByte) |=> curAddr == $past(rdData))
    else $error("byte pointer not used as byte address");
  // the load strobe follows every operand answer and frees the unit
  a_load_strobe: assert property (@(posedge mclk) disable iff (rst)
    s_operand_done |=> regLoad && !busy)
    else $error("operand answer gave no load");
  // the stepped address is the operand address plus one, wrapping
  a_step_addr: assert property (@(posedge mclk) disable iff (rst)
    s_operand_done |=> nextByteAddr == $past(curAddr) + 16'h0001)
    else $error("stepped byte address wrong");
  // an instruction fetch answer never loads the register
  a_fetch_no_load: assert property (@(posedge mclk) disable iff (rst)
    (state == ST_FETCH && rdValid) |=> !regLoad && state == ST_IDLE)
    else $error("fetch answer loaded the register");

  // ==========================================================
  // checks: addresses and mode
  // operand cycles follow the byte or word width latched at start
  a_operand_addr: assert property (@(posedge mclk) disable iff (rst)
    (state == ST_OPERAND) |-> memAddr == opAddrNow)
    else $error("operand address not in mode format");
  // pointer and fetch cycles are word addressed in either mode
  a_pointer_addr: assert property (@(posedge mclk) disable iff (rst)
    (state == ST_POINTER || state == ST_FETCH) |-> memAddr == wordAddrNow)
    else $error("pointer or fetch address not word format");
  // a word pointer hands on its low fifteen bits only
  a_chain_next: assert property (@(posedge mclk) disable iff (rst)
    (s_ptr_done and !opByte) |=> curAddr == {1'b0, $past(rdData[14:0])})
    else $error("word pointer location wrong");
  // a byte command alone enters byte mode
  a_mode_byte_cmd: assert property (@(posedge mclk) disable iff (rst)
    (setByteMode && !setWordMode) |=> byteMode)
    else $error("byte command ignored");
  // a word command enters word mode, even with a byte command beside it
  a_mode_word_cmd: assert property (@(posedge mclk) disable iff (rst)
    setWordMode |=> !byteMode)
    else $error("word command ignored");
endmodule

// *** dv/word_memory.sv ***
/*
  main memory model: 32768 words of 16 bits, one read at a time,
  read answer after a latency of one to four cycles.
  assumes memRead is a one-cycle pulse and memAddr holds meanwhile.
*/
`timescale 1ns/1ps
module word_memory (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic [15:0] memAddr,
  input  wire logic        memRead,
  input  wire logic [1:0]  lag,      // extra answer delay
  output      logic [15:0] rdData,
  output      logic        rdValid
);
  // ==========================================
  // storage and read pipeline
  logic [15:0] words [0:32767];      // full word space
  logic [14:0] addr;                 // latched word location
  logic [2:0]  waitCnt;              // cycles until the answer
  initial rdData = 16'h5a5a;
  // a released bus shows the inverse of its last value, so a stale
  // value never passes for data; each signal is written once per edge
  always @(posedge mclk) begin
    if (!rst && (waitCnt == 3'h1) && !memRead) begin
      rdValid <= 1'b1;
      rdData  <= words[addr];
    end else begin
      rdValid <= 1'b0;
      rdData  <= ~rdData;
    end
    if (rst) begin
      waitCnt <= 3'h0;
    end else if (memRead) begin
      addr    <= memAddr[14:0];
      waitCnt <= {1'b0, lag} + 3'h1;
    end else if (waitCnt != 3'h0) begin
      waitCnt <= waitCnt - 3'h1;
    end
  end
endmodule

// *** dv/byte_word_operand_addressing_tb.sv ***
/*
  testbench of the operand access unit: drives loads, fetches and
  peripheral stores; a monitor pops expected values from queues.
  assumes word_memory answers every read of the unit.
*/
`timescale 1ns/1ps
module byte_word_operand_addressing_tb;
  // ==========================================
  // signals
  logic        mclk, rst, setByteMode, setWordMode, start, indirect, fetchReq;
  logic        peripheralIn, rdValid, memRead, memWrite, regLoad, byteMode, busy;
  logic [14:0] fetchAddr;
  logic [7:0]  peripheralByte;
  logic [15:0] effAddr, rdData, memAddr, memWData, regData, nextByteAddr, a, w, p, e;
  logic [1:0]  lag;
  logic [15:0] loadQ[$], writeQ[$];  // expected loads and stores
  int          n_mismatch, cmp_count, seed, i;
  operand_access_pkg::op_class_t opClass;
  operand_access dut (.mclk(mclk), .rst(rst), .setByteMode(setByteMode),
    .setWordMode(setWordMode), .start(start), .opClass(opClass), .indirect(indirect),
    .effAddr(effAddr), .fetchReq(fetchReq), .fetchAddr(fetchAddr),
    .peripheralIn(peripheralIn), .peripheralByte(peripheralByte), .rdData(rdData),
    .rdValid(rdValid), .memAddr(memAddr), .memRead(memRead), .memWrite(memWrite),
    .memWData(memWData), .regData(regData), .regLoad(regLoad),
    .nextByteAddr(nextByteAddr), .byteMode(byteMode), .busy(busy));
  word_memory mem (.mclk(mclk), .rst(rst), .memAddr(memAddr), .memRead(memRead),
    .lag(lag), .rdData(rdData), .rdValid(rdValid));
  // ==========================================
  // checking and closing
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string s);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, s, seen, exp);
    end
  endtask
  task test_done;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // monitor: an unexpected strobe meets an unknown and fails
  always @(posedge mclk) begin
    if (memRead === 1'b1) check({15'h0000, memAddr[15]}, 16'h0000, "addr top");
    if (regLoad === 1'b1) begin
      e = (loadQ.size() > 0) ? loadQ.pop_front() : 16'hxxxx;
      check(regData, e, "load");
    end
    // the peripheral keeps only the low byte, so the high byte must be zero
    if (memWrite === 1'b1) begin
      e = (writeQ.size() > 0) ? writeQ.pop_front() : 16'hxxxx;
      check(memWData, e, "store");
    end
  end
  // ==========================================
  // drivers
  task automatic wait_idle;
    #1;
    repeat (40) begin
      if (busy === 1'b0) return;
      @(posedge mclk);
      #1;
    end
    n_mismatch++;
    test_done();
  endtask
  task automatic mode(input logic sb, input logic sw);
    @(posedge mclk);
    setByteMode <= sb;
    setWordMode <= sw;
    @(posedge mclk);
    setByteMode <= 1'b0;
    setWordMode <= 1'b0;
    #1 check({15'h0000, byteMode}, {15'h0000, sb & ~sw}, "mode");
  endtask
  task automatic op(input logic [2:0] c, input logic ind, input logic [15:0] ea, exp);
    @(posedge mclk);
    loadQ.push_back(exp);
    start <= 1'b1;
    opClass <= operand_access_pkg::op_class_t'(c);
    indirect <= ind;
    effAddr <= ea;
    lag <= 2'($random(seed));
    @(posedge mclk);
    start <= 1'b0;
    wait_idle();
  endtask
  // ==========================================
  // clock and main sequence
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    #300000;
    n_mismatch++;
    test_done();
  end
  initial begin
    seed = 32'ha18d_4a92;
    {setByteMode, setWordMode, start, indirect, fetchReq, peripheralIn} = 6'h00;
    {effAddr, fetchAddr, peripheralByte, lag} = '0;
    opClass = operand_access_pkg::OP_GENERAL;
    rst = 1'b1;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) begin
      a = 16'($random(seed));
      w = 16'($random(seed));
      mem.words[a[14:0]] = w;
      op(3'h0, 1'b0, a, w);
    end
    mode(1'b1, 1'b0);
    a = 16'($random(seed));
    for (i = 0; i < 4; i++) begin
      w = 16'($random(seed));
      mem.words[a[15:1]] = w;
      op(3'h0, 1'b0, a, {8'h00, a[0] ? w[7:0] : w[15:8]});
      @(posedge mclk);
      #1 check(nextByteAddr, a + 16'h0001, "step");
      a = a + 16'h0001;
    end
    for (i = 1; i < 7; i++) begin
      a = 16'($random(seed));
      w = 16'($random(seed));
      mem.words[a[14:0]] = w;
      op(3'(i), 1'b0, a, w);
    end
    // byte pointer with top bit set must still end after one level
    a = 16'h1234;
    p = 16'($random(seed)) | 16'h8000;
    w = 16'($random(seed));
    mem.words[a[14:0]] = p;
    mem.words[p[15:1]] = w;
    op(3'h0, 1'b1, a, {8'h00, p[0] ? w[7:0] : w[15:8]});
    @(posedge mclk);
    fetchReq <= 1'b1;
    fetchAddr <= 15'($random(seed));
    @(posedge mclk);
    fetchReq <= 1'b0;
    #1 check(memAddr, {1'b0, fetchAddr}, "fetch");
    wait_idle();
    @(posedge mclk);
    writeQ.push_back({8'h00, 8'hc3});
    peripheralIn <= 1'b1;
    peripheralByte <= 8'hc3;
    @(posedge mclk);
    peripheralIn <= 1'b0;
    repeat (3) @(posedge mclk);
    mode(1'b1, 1'b1);
    // three-level word chain ending on a clear top bit
    for (i = 1; i < 4; i++) mem.words[15'(i * 256)] = {i < 3, 15'((i + 1) * 256)};
    mem.words[15'h0400] = w;
    op(3'h0, 1'b1, 16'h0100, w);
    repeat (3) @(posedge mclk);
    check(16'(loadQ.size() + writeQ.size()), 16'h0000, "left over");
    test_done();
  end
endmodule
